/* src/lbrt_breath.sv */
`timescale 1ns/1ps
module lbrt_breath
   import lbrt_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Avalon-MM slave.
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   // LED drive.
   output logic o_pwm
);

   typedef struct packed {
      logic [7:0] cfg;
      logic wreq;
      logic [31:0] rdata;
      logic [7:0] cnt;
      logic [11:0] pre;
      logic [7:0] duty;
      lbrt_ramp_t ramp;
      logic [11:0] hold;
      logic pwm;
   } lbrt_st_t;

   lbrt_st_t s_q;
   lbrt_st_t s_d;

   logic [31:0] lim_w;
   logic [31:0] hold_w;
   logic [31:0] step_w;
   logic [1:0] ctl;
   logic [1:0] size;
   logic upd_en;
   logic asym;
   logic [7:0] size_max;
   logic [7:0] lim_max;
   logic [7:0] lim_min;
   logic [11:0] top_hold;
   logic [11:0] bot_hold;
   logic tick;
   logic period_end;
   logic falling;
   logic [2:0] seg;
   logic [3:0] field;
   logic [4:0] amt;
   logic [8:0] sum;
   logic [8:0] dif;
   logic [7:0] inc_v;
   logic [7:0] dec_v;
   logic acc;
   logic wr_en;
   logic ld_lim;
   logic ld_ramp;

   assign ctl = s_q.cfg[LBRT_CFG_CTL_LO +: 2];
   assign size = s_q.cfg[LBRT_CFG_SIZE_LO +: 2];
   assign upd_en = s_q.cfg[LBRT_CFG_UPD_BIT];
   assign asym = s_q.cfg[LBRT_CFG_ASYM_BIT];
   assign lim_max = lim_w[LBRT_LIM_MAX_LO +: 8];
   assign lim_min = lim_w[LBRT_LIM_MIN_LO +: 8];
   assign top_hold = hold_w[LBRT_HOLD_TOP_LO +: 12];
   assign bot_hold = hold_w[LBRT_HOLD_BOT_LO +: 12];

   // A bus access is taken in the cycle after it is seen, so waitrequest
   // is low for exactly one cycle per transfer.
   assign acc = (i_read || i_write) && s_q.wreq;
   assign wr_en = i_write && !s_q.wreq;

   // While the channel is off no period ends, so the limits, and hold and step when the update bit is set,
   // are passed straight through to keep a fresh enable from using stale data.
   assign ld_lim = period_end || (ctl == LBRT_CTL_OFF);
   assign ld_ramp = ld_lim && upd_en;

   lbrt_shadow_reg #(.MASK(LBRT_LIM_MASK)) u_lim (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr(wr_en && (i_address == LBRT_OFF_LIM)),
      .i_be(i_byteenable),
      .i_wdata(i_writedata),
      .i_load(ld_lim),
      .o_work(lim_w)
   );

   // Reserved top byte is masked off before it is stored.
   lbrt_shadow_reg #(.MASK(LBRT_HOLD_MASK)) u_hold (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr(wr_en && (i_address == LBRT_OFF_HOLD)),
      .i_be(i_byteenable),
      .i_wdata(i_writedata),
      .i_load(ld_ramp),
      .o_work(hold_w)
   );

   lbrt_shadow_reg #(.MASK(LBRT_STEP_MASK)) u_step (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr(wr_en && (i_address == LBRT_OFF_STEP)),
      .i_be(i_byteenable),
      .i_wdata(i_writedata),
      .i_load(ld_ramp),
      .o_work(step_w)
   );

   // Reserved size code behaves as 8-bit.
   always_comb begin
      unique case (size)
         LBRT_SIZE_7: size_max = LBRT_MAX_7;
         LBRT_SIZE_6: size_max = LBRT_MAX_6;
         default: size_max = LBRT_MAX_8;
      endcase
   end

   assign tick = (ctl == LBRT_CTL_BLINK) ? (s_q.pre == bot_hold) : 1'b1;
   assign period_end = tick && (s_q.cnt == size_max) &&
                       (ctl != LBRT_CTL_OFF);

   // Top hold belongs to the falling half so its exit step uses it.
   assign falling = (s_q.ramp == LBRT_FALL) || (s_q.ramp == LBRT_TOP);
   assign seg = asym ? {falling, s_q.duty[7:6]} : s_q.duty[7:5];
   assign field = step_w[{seg, 2'b00} +: 4];

   always_comb begin
      unique case (size)
         LBRT_SIZE_7: amt = {2'h0, field[3:1]} + 5'h01;
         LBRT_SIZE_6: amt = {3'h0, field[3:2]} + 5'h01;
         default: amt = {1'h0, field} + 5'h01;
      endcase
   end

   // Steps saturate at the ends of the duty range instead of wrapping.
   assign sum = {1'b0, s_q.duty} + {4'h0, amt};
   assign dif = {1'b0, s_q.duty} - {4'h0, amt};
   assign inc_v = (sum > {1'b0, size_max}) ? size_max : sum[7:0];
   assign dec_v = dif[8] ? 8'h00 : dif[7:0];

   always_comb begin
      s_d = s_q;
      s_d.wreq = !acc;
      if (wr_en && (i_address == LBRT_OFF_CFG)) begin
         for (int b = 0; b < 1; b++) begin
            if (i_byteenable[b]) begin
               s_d.cfg = i_writedata[7:0] & LBRT_CFG_MASK;
            end
         end
      end
      if (acc) begin
         s_d.rdata = LBRT_WORD_RST;
         if (i_read) begin
            unique case (i_address)
               LBRT_OFF_CFG: s_d.rdata = {24'h0, s_q.cfg};
               LBRT_OFF_LIM: s_d.rdata = lim_w;
               LBRT_OFF_HOLD: s_d.rdata = hold_w;
               LBRT_OFF_STEP: s_d.rdata = step_w;
               LBRT_OFF_STAT: s_d.rdata = {22'h0, s_q.ramp, s_q.duty};
               default: s_d.rdata = LBRT_WORD_RST;
            endcase
         end
      end
      // PWM period counter and blink prescaler.
      if (ctl == LBRT_CTL_OFF) begin
         s_d.cnt = 8'h00;
         s_d.pre = 12'h000;
      end else begin
         if (ctl == LBRT_CTL_BLINK) begin
            s_d.pre = (s_q.pre == bot_hold) ? 12'h000 : s_q.pre + 12'h001;
         end else begin
            s_d.pre = 12'h000;
         end
         if (tick) begin
            s_d.cnt = (s_q.cnt == size_max) ? 8'h00 : s_q.cnt + 8'h01;
         end
      end
      // Duty ramp.
      if (ctl != LBRT_CTL_BREATH) begin
         s_d.ramp = LBRT_RISE;
         s_d.hold = 12'h000;
         s_d.duty = (ctl == LBRT_CTL_BLINK) ? lim_min : 8'h00;
      end else if (period_end) begin
         unique case (s_q.ramp)
            LBRT_RISE: begin
               s_d.hold = 12'h000;
               if (s_q.duty >= lim_max) begin
                  s_d.ramp = LBRT_TOP;
               end else begin
                  s_d.duty = inc_v;
                  if (inc_v >= lim_max) begin
                     s_d.ramp = LBRT_TOP;
                  end
               end
            end
            LBRT_TOP: begin
               if (s_q.hold == top_hold) begin
                  s_d.duty = dec_v;
                  s_d.hold = 12'h000;
                  s_d.ramp = (dec_v <= lim_min) ? LBRT_BOT : LBRT_FALL;
               end else begin
                  s_d.hold = s_q.hold + 12'h001;
               end
            end
            LBRT_FALL: begin
               s_d.hold = 12'h000;
               if (s_q.duty <= lim_min) begin
                  s_d.ramp = LBRT_BOT;
               end else begin
                  s_d.duty = dec_v;
                  if (dec_v <= lim_min) begin
                     s_d.ramp = LBRT_BOT;
                  end
               end
            end
            LBRT_BOT: begin
               if (s_q.hold == bot_hold) begin
                  s_d.duty = inc_v;
                  s_d.hold = 12'h000;
                  s_d.ramp = (inc_v >= lim_max) ? LBRT_TOP : LBRT_RISE;
               end else begin
                  s_d.hold = s_q.hold + 12'h001;
               end
            end
         endcase
      end
      unique case (ctl)
         LBRT_CTL_OFF: s_d.pwm = 1'b0;
         LBRT_CTL_ON: s_d.pwm = 1'b1;
         default: s_d.pwm = (s_q.cnt < s_q.duty);
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '{cfg: LBRT_CFG_RST, wreq: 1'b1, rdata: LBRT_WORD_RST,
                  cnt: 8'h00, pre: 12'h000, duty: 8'h00, ramp: LBRT_RISE,
                  hold: 12'h000, pwm: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_readdata = s_q.rdata;
   assign o_waitrequest = s_q.wreq;
   assign o_pwm = s_q.pwm;

   bus_answer_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("Bus request not answered after one wait cycle.");

   read_work_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_read && !o_waitrequest && (i_address == LBRT_OFF_HOLD)
      |-> o_readdata == $past(hold_w))
      else $error("Hold read did not return working contents.");

   shadow_hold_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) !ld_ramp |=> (hold_w == $past(hold_w)) &&
      (step_w == $past(step_w)))
      else $error("Working copy changed without a load.");

   reserved_zero_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) hold_w[31:24] == 8'h00)
      else $error("Reserved hold bits are not zero.");

   top_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ctl == LBRT_CTL_BREATH) && period_end && (s_q.ramp == LBRT_TOP) &&
      (s_q.hold != top_hold) |=> s_q.duty == $past(s_q.duty))
      else $error("Duty moved during top hold.");

   bot_exit_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ctl == LBRT_CTL_BREATH) && period_end && (s_q.ramp == LBRT_BOT) &&
      (s_q.hold == bot_hold) |=> (s_q.duty == $past(s_q.duty) +
      {3'h0, $past(amt)}) || (s_q.duty == $past(size_max)))
      else $error("Duty not incremented at end of bottom hold.");

   step_eight_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) (size == LBRT_SIZE_8) && (s_q.ramp == LBRT_RISE)
      && (ctl == LBRT_CTL_BREATH) && period_end && (s_q.duty < lim_max)
      && (sum <= {1'b0, size_max})
      |=> s_q.duty == $past(s_q.duty) + {4'h0, $past(field)} + 8'h01)
      else $error("8-bit step is not field plus one.");

   step_small_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) (size == LBRT_SIZE_6) |-> amt <= 5'h04)
      else $error("6-bit step out of range.");

   off_reset_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ctl == LBRT_CTL_OFF) |=> !o_pwm && (s_q.cnt == 8'h00))
      else $error("Off mode left PWM running.");

   bot_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ctl == LBRT_CTL_BREATH) && period_end && (s_q.ramp == LBRT_BOT) &&
      (s_q.hold != bot_hold) |=> s_q.duty == $past(s_q.duty))
      else $error("Duty moved during bottom hold.");

   step_seven_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) (size == LBRT_SIZE_7) |->
      (amt != 5'h00) && (amt <= 5'h08))
      else $error("7-bit step out of range.");

   asym_index_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) asym && (s_q.ramp == LBRT_FALL) |->
      seg == {1'b1, s_q.duty[7:6]})
      else $error("Falling segment index is wrong.");

   blink_wait_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) (ctl == LBRT_CTL_BLINK) &&
      (s_q.pre != bot_hold) |=> s_q.cnt == $past(s_q.cnt))
      else $error("PWM counter moved between prescaler ticks.");

   rise_order_a: assert property (@(posedge i_clk)
      disable iff (!i_rst_n) (ctl == LBRT_CTL_BREATH) && period_end &&
      (s_q.ramp == LBRT_RISE) |=>
      (s_q.ramp == LBRT_RISE) || (s_q.ramp == LBRT_TOP))
      else $error("Rising ramp left for a wrong state.");

   on_high_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ctl == LBRT_CTL_ON) |=> o_pwm)
      else $error("Always-on mode left PWM low.");

endmodule : lbrt_breath

/* src/lbrt_pkg.sv */
package lbrt_pkg;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [5:0] LBRT_OFF_CFG = 6'h00;
   localparam logic [5:0] LBRT_OFF_LIM = 6'h04;
   localparam logic [5:0] LBRT_OFF_HOLD = 6'h08;
   localparam logic [5:0] LBRT_OFF_STEP = 6'h0C;
   localparam logic [5:0] LBRT_OFF_STAT = 6'h18;

   // Configuration register fields.
   localparam int LBRT_CFG_CTL_LO = 0;
   localparam int LBRT_CFG_SIZE_LO = 4;
   localparam int LBRT_CFG_UPD_BIT = 6;
   localparam int LBRT_CFG_ASYM_BIT = 7;
   localparam logic [7:0] LBRT_CFG_MASK = 8'hF3;
   localparam logic [7:0] LBRT_CFG_RST = 8'h00;

   // Channel control codes.
   localparam logic [1:0] LBRT_CTL_OFF = 2'h0;
   localparam logic [1:0] LBRT_CTL_BREATH = 2'h1;
   localparam logic [1:0] LBRT_CTL_BLINK = 2'h2;
   localparam logic [1:0] LBRT_CTL_ON = 2'h3;

   // PWM size codes and the top of each duty range.
   localparam logic [1:0] LBRT_SIZE_8 = 2'h0;
   localparam logic [1:0] LBRT_SIZE_7 = 2'h1;
   localparam logic [1:0] LBRT_SIZE_6 = 2'h2;
   localparam logic [7:0] LBRT_MAX_8 = 8'hFF;
   localparam logic [7:0] LBRT_MAX_7 = 8'h7F;
   localparam logic [7:0] LBRT_MAX_6 = 8'h3F;

   // Limits and hold-delay field layout.
   localparam int LBRT_LIM_MIN_LO = 0;
   localparam int LBRT_LIM_MAX_LO = 8;
   localparam logic [31:0] LBRT_LIM_MASK = 32'h0000FFFF;
   localparam int LBRT_HOLD_BOT_LO = 0;
   localparam int LBRT_HOLD_TOP_LO = 12;
   localparam logic [31:0] LBRT_HOLD_MASK = 32'h00FFFFFF;
   localparam logic [31:0] LBRT_STEP_MASK = 32'hFFFFFFFF;
   localparam logic [31:0] LBRT_WORD_RST = 32'h00000000;

   typedef enum logic [1:0] {
      LBRT_RISE,
      LBRT_TOP,
      LBRT_FALL,
      LBRT_BOT
   } lbrt_ramp_t;

endpackage : lbrt_pkg

/* src/lbrt_shadow_reg.sv */
`timescale 1ns/1ps
module lbrt_shadow_reg
   import lbrt_pkg::*;
#(
   parameter logic [31:0] MASK = 32'hFFFFFFFF
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Software write into the holding copy.
   input wire logic i_wr,
   input wire logic [3:0] i_be,
   input wire logic [31:0] i_wdata,
   // Transfer holding copy into the working copy.
   input wire logic i_load,
   // Working contents.
   output logic [31:0] o_work
);

   typedef struct packed {
      logic [31:0] shadow;
      logic [31:0] work;
   } lbrt_sh_t;

   lbrt_sh_t s_q;
   lbrt_sh_t s_d;

   always_comb begin
      s_d = s_q;
      if (i_wr) begin
         for (int b = 0; b < 4; b++) begin
            if (i_be[b]) begin
               s_d.shadow[b*8 +: 8] = i_wdata[b*8 +: 8] & MASK[b*8 +: 8];
            end
         end
      end
      // The load takes the old holding value, so a write racing a
      // period end lands at the next one.
      if (i_load) begin
         s_d.work = s_q.shadow;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '{shadow: LBRT_WORD_RST, work: LBRT_WORD_RST};
      end else begin
         s_q <= s_d;
      end
   end

   assign o_work = s_q.work;

endmodule : lbrt_shadow_reg

/* test/lbrt_breath_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) chk(32'(a), 32'(b))
module lbrt_breath_tb;
   import lbrt_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic [5:0] i_address = 6'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [3:0] i_byteenable = 4'hF;
   logic [31:0] i_writedata = 32'h00000000;
   logic [31:0] o_readdata;
   logic o_waitrequest;
   logic o_pwm;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [1:0] tsz [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
   logic [3:0] tfd [7] = '{4'hF, 4'h0, 4'hF, 4'h1, 4'hF, 4'h7, 4'h3};

   lbrt_breath u_lbrt_breath (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_address(i_address),
      .i_read(i_read),
      .i_write(i_write),
      .i_byteenable(i_byteenable),
      .i_writedata(i_writedata),
      .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest),
      .o_pwm(o_pwm)
   );

   always #50 i_clk = ~i_clk;

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // The ceiling leaves about two and a half times the expected run length.
   always @(posedge i_clk) begin
      cyc++;
      if (cyc >= 80000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_address <= a;
      i_writedata <= d;
      i_write <= 1'b1;
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      i_write <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge i_clk);
      i_address <= a;
      i_read <= 1'b1;
      do @(posedge i_clk); while (o_waitrequest !== 1'b0);
      d = o_readdata;
      i_read <= 1'b0;
   endtask : bus_rd

   // Status is sampled once a PWM period, always at the same phase, so
   // each sample pair spans exactly one period end of the ramp.
   task automatic ramp(input logic [31:0] cfg, input logic [31:0] lim,
         input logic [31:0] hold, input logic [31:0] step, input int n);
      logic [31:0] s0;
      logic [31:0] s1;
      logic [3:0] fld;
      logic [7:0] dlt;
      int p;
      int run;
      int idx;
      p = (cfg[5:4] == LBRT_SIZE_7) ? 128 :
          (cfg[5:4] == LBRT_SIZE_6) ? 64 : 256;
      bus_wr(LBRT_OFF_CFG, 32'h00000040);
      bus_wr(LBRT_OFF_LIM, lim);
      bus_wr(LBRT_OFF_HOLD, hold);
      bus_wr(LBRT_OFF_STEP, step);
      bus_wr(LBRT_OFF_CFG, cfg);
      bus_rd(LBRT_OFF_STAT, s0);
      run = -1;
      repeat (n) begin
         repeat (p - 3) @(posedge i_clk);
         bus_rd(LBRT_OFF_STAT, s1);
         idx = cfg[7] ? {s0[9:8] == LBRT_FALL, s0[7:6]} : s0[7:5];
         fld = step[idx * 4 +: 4];
         dlt = (cfg[5:4] == LBRT_SIZE_7) ? fld[3:1] + 8'h01 :
               (cfg[5:4] == LBRT_SIZE_6) ? fld[3:2] + 8'h01 : fld + 8'h01;
         if (s0[9:8] == LBRT_RISE && s1[9:8] == LBRT_RISE) begin
            `CHK(s1[7:0], s0[7:0] + dlt);
         end
         if (s0[9:8] == LBRT_FALL && s1[9:8] == LBRT_FALL) begin
            `CHK(s1[7:0], s0[7:0] - dlt);
         end
         if (s1[9:8] == LBRT_TOP || s1[9:8] == LBRT_BOT) begin
            if (s0[9:8] != s1[9:8]) begin
               run = (s0[9:8] == LBRT_RISE || s0[9:8] == LBRT_FALL) ? 1 : -1;
            end else if (run > 0) begin
               run++;
            end
         end else if (run > 0) begin
            if (s0[9:8] == LBRT_TOP) begin
               `CHK(run, hold[23:12] + 12'h001);
            end else begin
               `CHK(run, hold[11:0] + 12'h001);
            end
            run = -1;
         end
         s0 = s1;
      end
   endtask : ramp

   task automatic pwm_count(input int n, input int exp);
      int cnt;
      cnt = 0;
      repeat (n) begin
         @(posedge i_clk);
         if (o_pwm === 1'b1) cnt++;
      end
      `CHK(cnt, exp);
   endtask : pwm_count

   initial begin
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1'b1;
      bus_rd(LBRT_OFF_HOLD, rd);
      `CHK(rd, 32'h00000000);
      bus_rd(LBRT_OFF_STEP, rd);
      `CHK(rd, 32'h00000000);
      bus_wr(6'h10, 32'hFFFFFFFF);
      bus_rd(6'h10, rd);
      `CHK(rd, 32'h00000000);
      $display("test reset done");
      for (int k = 0; k < 7; k++) begin
         ramp(32'h00000041 | {26'h0, tsz[k], 4'h0},
            {16'h0, (tsz[k] == LBRT_SIZE_7) ? LBRT_MAX_7 :
            (tsz[k] == LBRT_SIZE_6) ? LBRT_MAX_6 : LBRT_MAX_8, 8'h00},
            32'h00000000, {8{tfd[k]}}, 4);
      end
      $display("test step sizes done");
      ramp(32'h00000041, 32'h0000C010, 32'h00001000, 32'hFEDCBA98, 50);
      $display("test symmetric ramp done");
      ramp(32'h000000C1, 32'h0000C010, 32'h00002003, 32'h9ABCDEF8, 50);
      $display("test asymmetric ramp done");
      bus_wr(LBRT_OFF_CFG, 32'h00000001);
      bus_wr(LBRT_OFF_HOLD, 32'hFFFFFFFF);
      bus_wr(LBRT_OFF_STEP, 32'h12345678);
      bus_rd(LBRT_OFF_HOLD, rd);
      `CHK(rd, 32'h00002003);
      repeat (300) @(posedge i_clk);
      bus_rd(LBRT_OFF_STEP, rd);
      `CHK(rd, 32'h9ABCDEF8);
      bus_wr(LBRT_OFF_CFG, 32'h00000041);
      repeat (300) @(posedge i_clk);
      bus_rd(LBRT_OFF_HOLD, rd);
      `CHK(rd, 32'h00FFFFFF);
      bus_rd(LBRT_OFF_STEP, rd);
      `CHK(rd, 32'h12345678);
      $display("test shadow done");
      bus_wr(LBRT_OFF_CFG, 32'h00000001);
      bus_wr(LBRT_OFF_HOLD, 32'h00ABCDEF);
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      bus_rd(LBRT_OFF_HOLD, rd);
      `CHK(rd, 32'h00000000);
      // Loading while off exposes the holding copy, which reset must clear.
      bus_wr(LBRT_OFF_CFG, 32'h00000040);
      bus_rd(LBRT_OFF_HOLD, rd);
      `CHK(rd, 32'h00000000);
      $display("test mid-run reset done");
      bus_wr(LBRT_OFF_CFG, 32'h00000060);
      bus_wr(LBRT_OFF_LIM, 32'h00000010);
      bus_wr(LBRT_OFF_HOLD, 32'h00000002);
      bus_wr(LBRT_OFF_CFG, 32'h00000062);
      repeat (400) @(posedge i_clk);
      pwm_count(384, 96);
      bus_wr(LBRT_OFF_CFG, 32'h00000063);
      repeat (4) @(posedge i_clk);
      pwm_count(64, 64);
      bus_wr(LBRT_OFF_CFG, 32'h00000060);
      repeat (4) @(posedge i_clk);
      pwm_count(64, 0);
      $display("test blink on off done");
      report_and_stop();
   end
endmodule : lbrt_breath_tb
